// ### qwe_consts.vh
`ifndef QWE_CONSTS_VH
`define QWE_CONSTS_VH

// Command opcodes.
`define QWE_OP_WRAP_READ 8'h0C
`define QWE_OP_WRAP_READ_DTR 8'h0E
`define QWE_OP_READ_PARAM 8'hC0
`define QWE_OP_FOUR_WIRE_ON 8'h38
`define QWE_OP_FOUR_WIRE_OFF 8'hFF
`define QWE_OP_WRITE_ENABLE 8'h06
`define QWE_OP_WRITE_DISABLE 8'h04
`define QWE_OP_READ_STATUS 8'h05
`define QWE_OP_PAGE_ERASE 8'h81
`define QWE_OP_SECTOR_ERASE 8'h20
`define QWE_OP_HALF_BLOCK_ERASE 8'h52
`define QWE_OP_FULL_BLOCK_ERASE 8'hD8
`define QWE_OP_RESET_ENABLE 8'h66
`define QWE_OP_RESET 8'h99

// Frame bit counts at which each phase ends, and the count saturation limit.
`define QWE_CMD_BITS 6'h08
`define QWE_PARAM_BITS 6'h10
`define QWE_ADDR_BITS 6'h20
`define QWE_MODE_BITS 6'h28
`define QWE_CNT_SAT 6'h3B

// Read parameter field positions and defaults.
`define QWE_DUMMY_FIELD_LSB 4
`define QWE_WRAP_FIELD_LSB 0
`define QWE_WRAP_DEFAULT 2'h0
`define QWE_DUMMY_DEFAULT 2'h0
`define QWE_DUMMY_SEL0 5'h0A
`define QWE_DUMMY_SEL1 5'h04
`define QWE_DUMMY_SEL2 5'h06
`define QWE_DUMMY_SEL3 5'h08
`define QWE_MODE_CONTINUE 2'h2

// Training pattern, driven most significant bit first.
`define QWE_TRAIN_PATTERN 8'h34

// Erase sizes in bytes.
`define QWE_LEN_PAGE 17'h00100
`define QWE_LEN_SECTOR 17'h01000
`define QWE_LEN_HALF_BLOCK 17'h08000
`define QWE_LEN_FULL_BLOCK 17'h10000

// Status byte layout.
`define QWE_STAT_BUSY_BIT 0
`define QWE_STAT_LATCH_BIT 1
`define QWE_STAT_PROTECT_LSB 2

// Hold count loaded when the array walk ends; the busy flag stays up one cycle more than this.
`define QWE_ERASE_HOLD_CYC 20'h00010

// Synchroniser reset value: chip select idle high, rest low.
`define QWE_SYNC_RESET 6'h01

`endif

// ### qwe_flash_seq.v
// Operation
// R01: 0Ch reads wrap within section, four-wire mode.
// R02: 0Eh double-rate read wraps the same way.
// R03: Reset gives 8-byte wrap, 10 dummy clocks.
// R04: Two-bit field picks 8/16/32/64 byte wrap.
// R05: Enable input drives pattern in dummy cycles.
// R06: Mode bits keep working; pattern follows them.
// R07: Pattern is fixed 00110100 every read.
// R08: Single rate pattern after mode, truncated.
// R09: Double rate pattern fills last four dummies.
// R10: 38h enters four-wire mode only if enabled.
// R11: Entering keeps latch, suspend and wrap.
// R12: FFh leaves four-wire mode, keeping state.
// R13: Host sets write latch before any erase.
// R14: 81h erases 256-byte page to ones.
// R15: Sector erase uses address bits from 12.
// R16: Erase needs select rising on byte boundary.
// R17: Select rise starts erase; busy then clears.
// R18: Protected sector is not erased.
// R19: Half block erase clears 32K bytes.
// R20: Protected half block unchanged, latch cleared.
// R21: Full block erase clears 64K unless protected.
// R22: Single wire mode uses only IO0 input.
// R23: Status reads answered while erase is busy.
`timescale 1ns/1ps
`include "qwe_consts.vh"

module qwe_flash_seq #(
  parameter [19:0] ERASE_HOLD_CYC = `QWE_ERASE_HOLD_CYC
) (
  input wire CLK_I,
  input wire RST_N_I,
  input wire CS_N_I,
  input wire SCLK_I,
  input wire [3:0] IO_I,
  output reg [3:0] IO_O,
  output reg [3:0] IO_OE_O,
  input wire QUAD_IO_ENABLE_I,
  input wire TRAINING_PATTERN_ENABLE_I,
  input wire [4:0] BLOCK_PROTECT_I,
  output reg FOUR_WIRE_COMMAND_MODE_O,
  output reg WRITE_ENABLE_LATCH_O,
  output reg WRITE_IN_PROGRESS_O
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD = 3'h1;
  localparam [2:0] ST_ADDR = 3'h2;
  localparam [2:0] ST_DUMMY = 3'h3;
  localparam [2:0] ST_DATA = 3'h4;
  localparam [2:0] ST_STAT = 3'h5;
  localparam [2:0] ST_IGN = 3'h6;

  // Shifts one nibble or one bit of the IO lines into the frame register.
  function [31:0] shift_in;
    input [31:0] s;
    input [3:0] d;
    input four;
    begin
      if (four) begin
        shift_in = {s[27:0], d};
      end else begin
        shift_in = {s[30:0], d[0]}; // [R22]
      end
    end
  endfunction

  // Next read address, wrapping inside the aligned section.
  function [21:0] wrap_next;
    input [21:0] a;
    input [1:0] sel;
    reg [5:0] m;
    reg [5:0] inc;
    begin
      case (sel)
        2'h0: m = 6'h07;
        2'h1: m = 6'h0F;
        2'h2: m = 6'h1F;
        default: m = 6'h3F;
      endcase
      inc = a[5:0] + 6'h01;
      wrap_next = {a[21:6], (a[5:0] & ~m) | (inc & m)}; // [R01] [R02] [R04]
    end
  endfunction

  // Dummy clock count for the dummy field value.
  function [4:0] dummy_of;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: dummy_of = `QWE_DUMMY_SEL0;
        2'h1: dummy_of = `QWE_DUMMY_SEL1;
        2'h2: dummy_of = `QWE_DUMMY_SEL2;
        default: dummy_of = `QWE_DUMMY_SEL3;
      endcase
    end
  endfunction

  // Size of the region cleared by an erase opcode.
  function [16:0] erase_len;
    input [7:0] o;
    begin
      case (o)
        `QWE_OP_PAGE_ERASE: erase_len = `QWE_LEN_PAGE; // [R14]
        `QWE_OP_SECTOR_ERASE: erase_len = `QWE_LEN_SECTOR; // [R15]
        `QWE_OP_HALF_BLOCK_ERASE: erase_len = `QWE_LEN_HALF_BLOCK; // [R19]
        default: erase_len = `QWE_LEN_FULL_BLOCK; // [R21]
      endcase
    end
  endfunction

  // Protection covers 2^(n-1) 64K blocks from the top, or bottom if bit 4.
  function is_prot;
    input [21:0] a;
    input [4:0] bp;
    reg [6:0] n;
    reg [6:0] blk;
    begin
      blk = {1'b0, a[21:16]};
      n = 7'h01 << (bp[3:0] - 4'h1);
      if (bp[3:0] == 4'h0) begin
        is_prot = 1'b0;
      end else if (bp[3:0] > 4'h6) begin
        is_prot = 1'b1;
      end else if (bp[4]) begin
        is_prot = (blk < n);
      end else begin
        is_prot = (blk >= (7'h40 - n));
      end
    end
  endfunction

  wire [5:0] sync_q;
  wire cs_n;
  wire sclk;
  wire [3:0] io;
  wire [7:0] rdata;
  reg cs_d;
  reg sclk_d;
  reg [2:0] state;
  reg [7:0] op;
  reg [31:0] sh;
  reg [5:0] cnt;
  reg [4:0] dcnt;
  reg half;
  reg [2:0] sbit;
  reg [1:0] wrap_sel;
  reg [1:0] dum_sel;
  reg cont;
  reg [7:0] cont_op;
  reg rst_armed;
  reg [21:0] rd_addr;
  reg er_walk;
  reg [21:0] er_addr;
  reg [16:0] er_left;
  reg [19:0] er_hold;

  qwe_sync u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i({IO_I, SCLK_I, CS_N_I}),
    .q_o(sync_q)
  );

  qwe_mem u_mem (
    .clk_i(CLK_I),
    .we_i(er_walk),
    .addr_i(er_walk ? er_addr : rd_addr),
    .wdata_i(8'hFF),
    .rdata_o(rdata)
  );

  // Synchronised pins and their edges.
  assign cs_n = sync_q[0];
  assign sclk = sync_q[1];
  assign io = sync_q[5:2];
  wire rise = sclk & ~sclk_d & ~cs_n;
  wire fall = ~sclk & sclk_d & ~cs_n;
  wire cs_rise = cs_n & ~cs_d;
  wire cs_fall = ~cs_n & cs_d;

  // Frame decode helpers.
  wire four_wire = FOUR_WIRE_COMMAND_MODE_O;
  wire [5:0] step = four_wire ? 6'h04 : 6'h01;
  wire [31:0] next_sh = shift_in(sh, io, four_wire);
  wire [5:0] next_cnt = (cnt > `QWE_CNT_SAT) ? cnt : cnt + step;
  wire [7:0] opc = next_sh[7:0];
  wire is_dtr = (op == `QWE_OP_WRAP_READ_DTR);
  wire is_read = (op == `QWE_OP_WRAP_READ) | is_dtr;
  wire is_erase = (op == `QWE_OP_PAGE_ERASE) | (op == `QWE_OP_SECTOR_ERASE) |
                  (op == `QWE_OP_HALF_BLOCK_ERASE) | (op == `QWE_OP_FULL_BLOCK_ERASE);
  wire [7:0] status = {1'b0, BLOCK_PROTECT_I, WRITE_ENABLE_LATCH_O, WRITE_IN_PROGRESS_O};
  wire [3:0] data_nib = half ? rdata[3:0] : rdata[7:4];

  // Erase target: aligned base and protection check.
  wire [16:0] elen = erase_len(op);
  wire [21:0] emask = {5'h00, elen - 17'h00001};
  wire [21:0] ebase = sh[21:0] & ~emask;
  wire eprot = is_prot(ebase, BLOCK_PROTECT_I);

  // Training pattern slot for falling and rising edges in dummy cycles.
  wire [7:0] pat = `QWE_TRAIN_PATTERN;
  wire [4:0] ndummy = dummy_of(dum_sel);
  wire [4:0] pbase = ndummy - 5'h04;
  wire [4:0] dnext = dcnt + 5'h01;
  wire [4:0] pf_off = dcnt - pbase;
  wire [4:0] pr_off = dnext - pbase;
  wire [4:0] pf_idx_s = dcnt - 5'h02;
  wire pf_ok_s = (dcnt >= 5'h02) && (dcnt < ndummy) && (pf_idx_s < 5'h08); // [R08]
  wire pf_ok_d = (dcnt >= pbase) && (dcnt < ndummy) && (dcnt >= 5'h02); // [R09]
  wire [4:0] pf_idx = is_dtr ? {pf_off[3:0], 1'b0} : pf_idx_s;
  wire pf_ok = TRAINING_PATTERN_ENABLE_I & (is_dtr ? pf_ok_d : pf_ok_s); // [R05] [R06]
  wire [4:0] pr_idx = {pr_off[3:0], 1'b0} - 5'h01;
  wire pr_ok = TRAINING_PATTERN_ENABLE_I & is_dtr & (dnext > pbase) &&
               (dnext <= ndummy) && (dnext >= 5'h02); // [R09]
  wire pf_bit = pat[3'h7 - pf_idx[2:0]]; // [R07]
  wire pr_bit = pat[3'h7 - pr_idx[2:0]]; // [R07]

  // Edge history for the synchronised select and clock.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_d <= cs_n;
      sclk_d <= sclk;
    end
  end

  // Frame sequencer, settings and erase engine.
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      op <= 8'h00;
      sh <= 32'h00000000;
      cnt <= 6'h00;
      dcnt <= 5'h00;
      half <= 1'b0;
      sbit <= 3'h0;
      wrap_sel <= `QWE_WRAP_DEFAULT; // [R03]
      dum_sel <= `QWE_DUMMY_DEFAULT; // [R03]
      cont <= 1'b0;
      cont_op <= 8'h00;
      rst_armed <= 1'b0;
      rd_addr <= 22'h000000;
      er_walk <= 1'b0;
      er_addr <= 22'h000000;
      er_left <= 17'h00000;
      er_hold <= 20'h00000;
      IO_O <= 4'h0;
      IO_OE_O <= 4'h0;
      FOUR_WIRE_COMMAND_MODE_O <= 1'b0;
      WRITE_ENABLE_LATCH_O <= 1'b0;
      WRITE_IN_PROGRESS_O <= 1'b0;
    end else begin
      // Self-timed erase: walk the region writing ones, then hold busy.
      if (er_walk) begin
        er_addr <= er_addr + 22'h000001;
        er_left <= er_left - 17'h00001;
        if (er_left == 17'h00001) begin
          er_walk <= 1'b0;
          er_hold <= ERASE_HOLD_CYC;
        end
      end else if (WRITE_IN_PROGRESS_O) begin
        if (er_hold == 20'h00000) begin
          WRITE_IN_PROGRESS_O <= 1'b0; // [R17]
          WRITE_ENABLE_LATCH_O <= 1'b0; // [R17]
        end else begin
          er_hold <= er_hold - 20'h00001;
        end
      end

      if (cs_fall) begin
        // A remembered continuous mode skips the opcode.
        IO_OE_O <= 4'h0;
        half <= 1'b0;
        sbit <= 3'h0;
        dcnt <= 5'h00;
        if (cont && four_wire && !WRITE_IN_PROGRESS_O) begin
          state <= ST_ADDR; // [R06]
          op <= cont_op;
          cnt <= `QWE_CMD_BITS;
        end else begin
          state <= ST_CMD;
          op <= 8'h00;
          cnt <= 6'h00;
        end
      end else if (cs_rise) begin
        // Commands take effect when select rises on their exact length.
        state <= ST_IDLE;
        IO_OE_O <= 4'h0;
        if (!WRITE_IN_PROGRESS_O) begin
          if (op != `QWE_OP_RESET_ENABLE && cnt == `QWE_CMD_BITS) begin
            rst_armed <= 1'b0;
          end
          case (op)
            `QWE_OP_WRITE_ENABLE: begin
              if (cnt == `QWE_CMD_BITS) begin
                WRITE_ENABLE_LATCH_O <= 1'b1;
              end
            end
            `QWE_OP_WRITE_DISABLE: begin
              if (cnt == `QWE_CMD_BITS) begin
                WRITE_ENABLE_LATCH_O <= 1'b0;
              end
            end
            `QWE_OP_FOUR_WIRE_ON: begin
              if (cnt == `QWE_CMD_BITS && !four_wire && QUAD_IO_ENABLE_I) begin
                FOUR_WIRE_COMMAND_MODE_O <= 1'b1; // [R10] [R11]
              end
            end
            `QWE_OP_FOUR_WIRE_OFF: begin
              if (cnt == `QWE_CMD_BITS && four_wire) begin
                FOUR_WIRE_COMMAND_MODE_O <= 1'b0; // [R12]
              end
            end
            `QWE_OP_RESET_ENABLE: begin
              if (cnt == `QWE_CMD_BITS) begin
                rst_armed <= 1'b1;
              end
            end
            `QWE_OP_RESET: begin
              if (cnt == `QWE_CMD_BITS && rst_armed) begin
                wrap_sel <= `QWE_WRAP_DEFAULT; // [R03]
                dum_sel <= `QWE_DUMMY_DEFAULT; // [R03]
                cont <= 1'b0;
                WRITE_ENABLE_LATCH_O <= 1'b0;
              end
            end
            `QWE_OP_READ_PARAM: begin
              if (cnt == `QWE_PARAM_BITS) begin
                dum_sel <= sh[`QWE_DUMMY_FIELD_LSB+1:`QWE_DUMMY_FIELD_LSB]; // [R04]
                wrap_sel <= sh[`QWE_WRAP_FIELD_LSB+1:`QWE_WRAP_FIELD_LSB]; // [R04]
              end
            end
            default: begin
              // Erase needs the latch and a full 32-bit frame.
              if (is_erase && cnt == `QWE_ADDR_BITS && WRITE_ENABLE_LATCH_O) begin // [R13] [R16]
                if (eprot) begin
                  WRITE_ENABLE_LATCH_O <= 1'b0; // [R18] [R20] [R21]
                end else begin
                  er_walk <= 1'b1; // [R14] [R15] [R19] [R21]
                  er_addr <= ebase;
                  er_left <= elen;
                  WRITE_IN_PROGRESS_O <= 1'b1; // [R17]
                end
              end
            end
          endcase
        end
      end else if (rise) begin
        case (state)
          ST_CMD: begin
            sh <= next_sh;
            cnt <= next_cnt;
            if (next_cnt == `QWE_CMD_BITS) begin
              op <= opc;
              if (opc == `QWE_OP_READ_STATUS) begin
                state <= ST_STAT; // [R23]
              end else if (WRITE_IN_PROGRESS_O) begin
                state <= ST_IGN; // [R23]
              end else if (four_wire && (opc == `QWE_OP_WRAP_READ ||
                       opc == `QWE_OP_WRAP_READ_DTR || opc == `QWE_OP_READ_PARAM)) begin
                state <= ST_ADDR; // [R01] [R02]
              end else if (opc == `QWE_OP_PAGE_ERASE || opc == `QWE_OP_SECTOR_ERASE ||
                       opc == `QWE_OP_HALF_BLOCK_ERASE ||
                       opc == `QWE_OP_FULL_BLOCK_ERASE) begin
                state <= ST_ADDR;
              end else begin
                state <= ST_IGN;
              end
            end
          end
          ST_ADDR, ST_IGN: begin
            sh <= next_sh;
            cnt <= next_cnt;
            if (state == ST_ADDR && is_read && next_cnt == `QWE_ADDR_BITS) begin
              state <= ST_DUMMY;
              rd_addr <= next_sh[21:0];
            end
          end
          ST_DUMMY: begin
            dcnt <= dnext;
            if (cnt < `QWE_MODE_BITS) begin
              sh <= next_sh;
              cnt <= next_cnt;
              if (next_cnt == `QWE_MODE_BITS) begin
                cont <= (next_sh[5:4] == `QWE_MODE_CONTINUE); // [R06]
                cont_op <= op;
              end
            end
            if (pr_ok) begin
              IO_O <= {4{pr_bit}}; // [R09]
              IO_OE_O <= 4'hF;
            end else begin
              IO_OE_O <= 4'h0;
            end
          end
          ST_DATA: begin
            if (is_dtr) begin
              IO_O <= data_nib; // [R02]
              IO_OE_O <= 4'hF;
              half <= ~half;
              if (half) begin
                rd_addr <= wrap_next(rd_addr, wrap_sel); // [R02]
              end
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end else if (fall) begin
        case (state)
          ST_ADDR: begin
            // The fall after the last opcode rise carries no address nibble.
            if (is_dtr && cnt > `QWE_CMD_BITS) begin
              sh <= next_sh;
              cnt <= next_cnt;
              if (next_cnt == `QWE_ADDR_BITS) begin
                state <= ST_DUMMY;
                rd_addr <= next_sh[21:0];
              end
            end
          end
          ST_DUMMY: begin
            if (is_dtr && cnt < `QWE_MODE_BITS) begin
              sh <= next_sh;
              cnt <= next_cnt;
              if (next_cnt == `QWE_MODE_BITS) begin
                cont <= (next_sh[5:4] == `QWE_MODE_CONTINUE); // [R06]
                cont_op <= op;
              end
            end
            if (dcnt == ndummy) begin
              state <= ST_DATA;
              IO_O <= data_nib; // [R01]
              IO_OE_O <= 4'hF;
              half <= 1'b1;
            end else if (pf_ok) begin
              IO_O <= {4{pf_bit}}; // [R08] [R09]
              IO_OE_O <= 4'hF;
            end else begin
              IO_OE_O <= 4'h0;
            end
          end
          ST_DATA: begin
            IO_O <= data_nib;
            IO_OE_O <= 4'hF;
            half <= ~half;
            if (half) begin
              rd_addr <= wrap_next(rd_addr, wrap_sel); // [R01]
            end
          end
          ST_STAT: begin
            // Status repeats for as long as select stays low.
            sbit <= sbit + 3'h1;
            if (four_wire) begin
              IO_O <= sbit[0] ? status[3:0] : status[7:4]; // [R23]
              IO_OE_O <= 4'hF;
            end else begin
              IO_O <= {2'b00, status[3'h7 - sbit], 1'b0}; // [R23]
              IO_OE_O <= 4'h2;
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end

endmodule

// ### qwe_flash_seq_asserts.sv
`timescale 1ns/1ps
module qwe_flash_seq_chk #(
  parameter [19:0] ERASE_HOLD_CYC = 20'h00010
) (
  input wire CLK_I,
  input wire RST_N_I,
  input wire CS_N_I,
  input wire SCLK_I,
  input wire [3:0] IO_I,
  input wire [3:0] IO_O,
  input wire [3:0] IO_OE_O,
  input wire QUAD_IO_ENABLE_I,
  input wire TRAINING_PATTERN_ENABLE_I,
  input wire [4:0] BLOCK_PROTECT_I,
  input wire FOUR_WIRE_COMMAND_MODE_O,
  input wire WRITE_ENABLE_LATCH_O,
  input wire WRITE_IN_PROGRESS_O
);
  // All checks share the system clock and drop out while reset is low.
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // Select has been idle long enough for a frame to have closed.
  sequence s_cs_closed;
    CS_N_I && $past(CS_N_I, 2);
  endsequence
  // An erase keeps the busy flag up for at least eight cycles.
  sequence s_busy_run;
    WRITE_IN_PROGRESS_O [*8];
  endsequence

  property p_busy_after_cs;
    $rose(WRITE_IN_PROGRESS_O) |-> s_cs_closed;
  endproperty
  a_busy_after_cs: assert property (p_busy_after_cs) else $error("busy rose inside a frame");
  property p_busy_holds;
    $rose(WRITE_IN_PROGRESS_O) |-> s_busy_run;
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy dropped too early");
  property p_busy_end;
    $fell(WRITE_IN_PROGRESS_O) |-> !WRITE_ENABLE_LATCH_O;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("latch kept after erase end");
  property p_busy_needs_latch;
    $rose(WRITE_IN_PROGRESS_O) |-> $past(WRITE_ENABLE_LATCH_O);
  endproperty
  a_busy_needs_latch: assert property (p_busy_needs_latch) else $error("erase without latch");
  property p_latch_in_busy;
    WRITE_IN_PROGRESS_O |-> WRITE_ENABLE_LATCH_O;
  endproperty
  a_latch_in_busy: assert property (p_latch_in_busy) else $error("latch low while busy");
  property p_mode_needs_qe;
    $rose(FOUR_WIRE_COMMAND_MODE_O) |-> $past(QUAD_IO_ENABLE_I);
  endproperty
  a_mode_needs_qe: assert property (p_mode_needs_qe) else $error("mode entered without enable");
  property p_mode_on_cs;
    $changed(FOUR_WIRE_COMMAND_MODE_O) |-> s_cs_closed;
  endproperty
  a_mode_on_cs: assert property (p_mode_on_cs) else $error("mode changed inside a frame");
  property p_mode_keeps_latch;
    $changed(FOUR_WIRE_COMMAND_MODE_O) |-> $stable(WRITE_ENABLE_LATCH_O);
  endproperty
  a_mode_keeps_latch: assert property (p_mode_keeps_latch) else $error("latch moved on mode change");
  property p_single_io0;
    !FOUR_WIRE_COMMAND_MODE_O && !$past(FOUR_WIRE_COMMAND_MODE_O, 8) |-> !IO_OE_O[0];
  endproperty
  a_single_io0: assert property (p_single_io0) else $error("input line driven in single mode");
  property p_no_erase_all_prot;
    $rose(WRITE_IN_PROGRESS_O) |-> $past(BLOCK_PROTECT_I[3:0]) < 4'h7;
  endproperty
  a_no_erase_all_prot: assert property (p_no_erase_all_prot) else $error("erase in protected area");
endmodule

bind qwe_flash_seq qwe_flash_seq_chk #(.ERASE_HOLD_CYC(ERASE_HOLD_CYC)) i_chk (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CS_N_I(CS_N_I), .SCLK_I(SCLK_I), .IO_I(IO_I),
  .IO_O(IO_O), .IO_OE_O(IO_OE_O), .QUAD_IO_ENABLE_I(QUAD_IO_ENABLE_I),
  .TRAINING_PATTERN_ENABLE_I(TRAINING_PATTERN_ENABLE_I), .BLOCK_PROTECT_I(BLOCK_PROTECT_I),
  .FOUR_WIRE_COMMAND_MODE_O(FOUR_WIRE_COMMAND_MODE_O),
  .WRITE_ENABLE_LATCH_O(WRITE_ENABLE_LATCH_O), .WRITE_IN_PROGRESS_O(WRITE_IN_PROGRESS_O));

// ### qwe_host.sv
`timescale 1ns/1ps
module qwe_host (
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io,
  input wire logic [3:0] io_w
);
  integer seed = 82169;

  // Idle bus: select high, serial clock parked low between frames.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io = 4'h0;
  end

  // One frame of whole units: bits out on line 0 and in on line 1, or nibbles on all four lines.
  task xfer(input logic four, input integer n_out, input logic [63:0] d,
            input integer n_in, output logic [63:0] rd);
    integer k;
    begin
      rd = 64'h0;
      cs_n <= 1'b0;
      #62.5;
      for (k = 0; k < n_out + n_in; k = k + 1) begin
        if (k >= n_out)
          io <= ~io; // Released lines keep changing.
        else if (four)
          io <= d[63 - 4 * k -: 4];
        else
          io <= {3'($random(seed)), d[63 - k]};
        #62.5;
        if (k >= n_out)
          rd = four ? {rd[59:0], io_w} : {rd[62:0], io_w[1]};
        sclk <= 1'b1;
        #62.5 sclk <= 1'b0;
      end
      #62.5 cs_n <= 1'b1;
      io <= ~io;
      #500;
    end
  endtask

  // Double rate frame: one nibble slot per clock edge, the first edge a rise.
  // Slots that carry nothing take a filler nibble; the last 16 nibbles read are kept.
  task xfer_dtr(input integer n_out, input logic [63:0] d, input integer n_in,
                output logic [63:0] rd);
    integer k;
    begin
      rd = 64'h0;
      cs_n <= 1'b0;
      #31.25;
      for (k = 0; k < n_out + n_in; k = k + 1) begin
        if (k >= n_out)
          io <= ~io;
        else
          io <= d[63 - 4 * k -: 4];
        #31.25;
        if (k >= n_out)
          rd = {rd[59:0], io_w};
        sclk <= ~sclk;
        #31.25;
      end
      #31.25 cs_n <= 1'b1;
      io <= ~io;
      #500;
    end
  endtask
endmodule

// ### qwe_mem.v
`timescale 1ns/1ps

module qwe_mem (
  input wire clk_i,
  input wire we_i,
  input wire [21:0] addr_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o
);

  reg [7:0] mem [0:4194303];

  // Single port array; read data is registered.
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule

// ### qwe_sync.v
`timescale 1ns/1ps
`include "qwe_consts.vh"

module qwe_sync (
  input wire clk_i,
  input wire rst_n_i,
  input wire [5:0] d_i,
  output reg [5:0] q_o
);

  reg [5:0] meta;

  // Two flops per pin; only the second stage is seen by other logic.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= `QWE_SYNC_RESET;
      q_o <= `QWE_SYNC_RESET;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic quad_en = 1'b0;
  logic tpe = 1'b0;
  logic [4:0] bp = 5'h00;
  wire cs_n;
  wire sclk;
  wire fwm;
  wire latch;
  wire busy;
  wire [3:0] host_io;
  wire [3:0] io_o;
  wire [3:0] io_oe;
  wire [3:0] io_w;
  integer n_fail = 0;
  integer samples_checked = 0;
  integer m_latch = 0;
  integer m_mode = 0;
  integer busy_cnt = 0;
  integer b0;
  integer i;
  integer k;
  int pat_q[$];
  int len_q[$] = '{256, 4096, 65536};
  logic [7:0] ops[4] = '{8'h81, 8'h20, 8'h52, 8'hD8};
  logic [23:0] adr[3] = '{24'h000200, 24'h001ABC, 24'h02FFFF};
  logic [23:0] rda[3] = '{24'h000238, 24'h001FFF, 24'h02FFFF};
  logic [63:0] rd;

  // System clock at 200 MHz.
  initial forever #2.5 clk_i = ~clk_i;

  // Wire level: the device wins on lines it enables.
  assign io_w = (io_oe & io_o) | (~io_oe & host_io);

  qwe_flash_seq #(.ERASE_HOLD_CYC(20'h00004)) i_dut (.CLK_I(clk_i), .RST_N_I(rst_n_i),
    .CS_N_I(cs_n), .SCLK_I(sclk), .IO_I(io_w), .IO_O(io_o), .IO_OE_O(io_oe),
    .QUAD_IO_ENABLE_I(quad_en), .TRAINING_PATTERN_ENABLE_I(tpe), .BLOCK_PROTECT_I(bp),
    .FOUR_WIRE_COMMAND_MODE_O(fwm), .WRITE_ENABLE_LATCH_O(latch), .WRITE_IN_PROGRESS_O(busy));
  qwe_host i_host (.cs_n(cs_n), .sclk(sclk), .io(host_io), .io_w(io_w));

  // Counts every cycle with the busy flag up.
  always @(posedge clk_i) if (busy) busy_cnt <= busy_cnt + 1;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task cyc(input integer n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task cmd(input logic four, input logic [7:0] op);
    i_host.xfer(four, four ? 2 : 8, {op, 56'h0}, 0, rd);
    if (op == 8'h06) m_latch = 1;
  endtask

  task erase(input logic [7:0] op, input logic [23:0] a, input integer nbits);
    i_host.xfer(1'b0, nbits, {op, a, 32'h0}, 0, rd);
  endtask

  // Cuts a hang short.
  initial begin
    #495000;
    n_fail = n_fail + 1;
    end_of_test;
  end

  // Main sequence.
  initial begin
    for (k = 0; k < 8; k = k + 1) pat_q.push_back(((8'h34 >> (7 - k)) & 1) ? 15 : 0);
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(5);
    chk({io_oe, fwm, latch, busy}, 7'h00);
    cmd(1'b0, 8'h38);
    cyc(20);
    chk(fwm, m_mode);
    erase(8'h20, 24'h001000, 32);
    cyc(20);
    chk({latch, busy}, 2'b00);
    cmd(1'b0, 8'h06);
    erase(8'h20, 24'h001000, 31);
    cyc(20);
    chk({latch, busy}, 2'b10);
    @(posedge clk_i) bp <= 5'h07;
    for (i = 0; i < 4; i = i + 1) begin
      cmd(1'b0, 8'h06);
      erase(ops[i], 24'h3F0000, 32);
      m_latch = 0;
      cyc(20);
      chk({latch, busy}, {m_latch[0], 1'b0});
    end
    @(posedge clk_i) bp <= 5'h00;
    for (i = 0; i < 3; i = i + 1) begin
      cmd(1'b0, 8'h06);
      b0 = busy_cnt;
      erase(ops[i == 2 ? 3 : i], adr[i], 32);
      cyc(10);
      chk(busy, 1'b1);
      rd = 64'h1;
      for (k = 0; k < 400 && rd[0] !== 1'b0; k = k + 1) begin
        i_host.xfer(1'b0, 8, {8'h05, 56'h0}, 8, rd);
        if (rd[0] === 1'b1) chk(rd[7:1], {1'b0, bp, 1'b1});
      end
      // A poll may straddle the end of busy, so read the settled status once more.
      i_host.xfer(1'b0, 8, {8'h05, 56'h0}, 8, rd);
      m_latch = 0;
      chk(rd[7:0], {1'b0, bp, m_latch[0], 1'b0});
      chk(busy_cnt - b0, len_q[i] + 4 + 1);
    end
    cmd(1'b0, 8'h06);
    @(posedge clk_i) quad_en <= 1'b1;
    cmd(1'b0, 8'h38);
    m_mode = 1;
    cyc(20);
    chk({fwm, latch}, {m_mode[0], m_latch[0]});
    @(posedge clk_i) tpe <= 1'b1;
    // Four dummy clocks leave room for two pattern bits before the data.
    i_host.xfer(1'b1, 4, {8'hC0, 8'h10, 48'h0}, 0, rd);
    i_host.xfer(1'b1, 10, {8'h0C, 24'h0002FF, 32'h0}, 6, rd);
    for (k = 0; k < 2; k = k + 1) chk(rd[23 - 4 * k -: 4], pat_q[k]);
    chk(rd[15:0], 16'hFFFF);
    // The reset command restores the defaults and drops the latch.
    cmd(1'b1, 8'h66);
    cmd(1'b1, 8'h99);
    m_latch = 0;
    cyc(20);
    chk(latch, m_latch);
    cmd(1'b1, 8'h06);
    for (i = 0; i < 3; i = i + 1) begin
      i_host.xfer(1'b1, 10, {8'h0C, rda[i], 8'h00, 24'h0}, 12, rd);
      for (k = 0; k < 8; k = k + 1) chk(rd[47 - 4 * k -: 4], pat_q[k]);
      chk(rd[15:0], 16'hFFFF);
    end
    // Mode bits 10 let the next frame start straight at the address.
    i_host.xfer(1'b1, 10, {8'h0C, 24'h001FFF, 8'h20, 24'h0}, 12, rd);
    i_host.xfer(1'b1, 8, {24'h001FFF, 8'h00, 32'h0}, 12, rd);
    for (k = 0; k < 8; k = k + 1) chk(rd[47 - 4 * k -: 4], pat_q[k]);
    chk(rd[15:0], 16'hFFFF);
    // Double rate: opcode on two rises, then a nibble on every edge from the next rise on.
    i_host.xfer_dtr(12, {16'h00E0, 24'h0002FF, 8'h00, 16'h0}, 22, rd);
    for (k = 0; k < 8; k = k + 1) chk(rd[47 - 4 * k -: 4], pat_q[k]);
    chk(rd[15:0], 16'hFFFF);
    cmd(1'b1, 8'hFF);
    m_mode = 0;
    cyc(20);
    chk({fwm, latch}, {m_mode[0], m_latch[0]});
    end_of_test;
  end
endmodule
